// >>> logic/pwm_timer_pkg.sv
/*
  Shared constants for the match-based PWM timer: register offsets,
  field positions, reset values and the count-source encoding.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
*/
package pwm_timer_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00; // Run, hold, mode, source
  localparam logic [7:0] OFF_COUNT = 8'h04; // Timer counter
  localparam logic [7:0] OFF_PRESCALE = 8'h08; // Prescale terminal value
  localparam logic [7:0] OFF_PCOUNT = 8'h0c; // Prescale counter
  localparam logic [7:0] OFF_MATCH_CTRL = 8'h10; // Per-match actions
  localparam logic [7:0] OFF_PWM_SEL = 8'h14; // Edge kind and output enables
  localparam logic [7:0] OFF_RELEASE = 8'h18; // Shadow release bits
  localparam logic [7:0] OFF_INT_STAT = 8'h1c; // Sticky match events, RO
  localparam logic [7:0] OFF_INT_CLR = 8'h20; // Write one to clear, WO
  localparam logic [7:0] OFF_INT_EN = 8'h24; // Interrupt enables
  localparam logic [7:0] OFF_MATCH0 = 8'h40; // Match i at OFF_MATCH0 + 4*i
  // Control fields
  localparam int CTRL_RUN_BIT = 0; // Counter enable
  localparam int CTRL_HOLD_BIT = 1; // Hold counters at zero
  localparam int CTRL_PWM_BIT = 2; // PWM mode enable
  localparam int CTRL_SRC_LSB = 4; // Count source, two bits
  localparam int CTRL_CAPSEL_BIT = 6; // Capture input select
  // Match control fields, three bits per comparator
  localparam int MC_INT = 0; // Raise event
  localparam int MC_RST = 1; // Clear counter
  localparam int MC_STOP = 2; // Halt counter
  localparam int MC_WIDTH = 3;
  // PWM select fields
  localparam int SEL_DOUBLE_LSB = 0; // Bit n: output n double-edge for n 2 to 6; bit 1 is held at zero
  localparam int SEL_OE_LSB = 8; // Bit 8+n: output n enabled
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Count source
  typedef enum logic [1:0] {
    SRC_CLOCK = 2'h0,
    SRC_RISE = 2'h1,
    SRC_FALL = 2'h2,
    SRC_BOTH = 2'h3
  } count_src_t;
endpackage : pwm_timer_pkg

// >>> logic/pwm_out_if.sv
/*
  Carrier between the timer core and the output edge stage.
  Assumes both ends sit on the same ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface pwm_out_if;
  logic [6:0] matchHit; // One-cycle match pulses, bit 0 starts a cycle
  logic [6:1] doubleSel; // Output n uses matches n-1 and n
  logic [6:1] outEn; // Output n drives its pin
  logic [6:1] pwmOut; // Registered output levels
  modport core (output matchHit, output doubleSel, output outEn, input pwmOut);
  modport edges (input matchHit, input doubleSel, input outEn, output pwmOut);
endinterface : pwm_out_if
`default_nettype wire

// >>> logic/pwm_edge_gen.sv
/*
  Output edge stage: turns match pulses into six PWM levels.
  Assumes match pulses are one cycle wide and come from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pwm_edge_gen (
  input wire logic ref_clk,
  input wire logic rst_b,
  pwm_out_if.edges bus
);
  logic [6:1] level_r; // Raw output levels
  logic [6:1] level_nxt;

  // set and clear
  // Set and clear events per output; clear wins on a tie
  always_comb begin
    level_nxt = level_r;
    for (int n = 1; n <= 6; n++) begin
      if (bus.matchHit[n]) begin
        level_nxt[n] = 1'b0;
      end else if (bus.doubleSel[n] ? bus.matchHit[n-1] : bus.matchHit[0]) begin
        level_nxt[n] = 1'b1;
      end
    end
  end

  // Level registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      level_r <= '0;
    end else begin
      level_r <= level_nxt;
    end
  end

  // Gated pin levels, registered
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bus.pwmOut <= '0;
    end else begin
      bus.pwmOut <= level_nxt & bus.outEn;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_single_rise: assert property (
    bus.matchHit[0] && !bus.matchHit[1] && !bus.doubleSel[1] && bus.outEn[1]
    |=> bus.pwmOut[1]) else $error("single-edge output did not rise at cycle start");
  a_double_rise: assert property (
    bus.doubleSel[2] && bus.matchHit[1] && !bus.matchHit[2] && bus.outEn[2]
    |=> bus.pwmOut[2]) else $error("double-edge output did not rise on its set match");
  a_fall_edge: assert property (
    bus.matchHit[3] |=> !bus.pwmOut[3] && !level_r[3])
    else $error("output did not fall on its clear match");
  c_negative_pulse: cover property (
    bus.doubleSel[2] && bus.matchHit[2] ##[1:50] bus.matchHit[1]);
endmodule : pwm_edge_gen
`default_nettype wire

// >>> logic/pwm_timer.sv
/*
  Match-based PWM timer: 32-bit counter, 32-bit prescaler, seven match
  comparators with shadow registers, APB register file and one
  level interrupt. Assumes a single 50 MHz ref_clk and capture pins
  that are asynchronous to it.
*/
// Notes on behaviour
// - Counts clock or selected capture edges.
// - Seven comparators feed six PWM outputs.
// - Match may just raise an event.
// - Match may halt the counter.
// - Match may clear the counter.
// - Single-edge outputs rise at cycle start.
// - Double-edge edges sit anywhere in cycle.
// - Period and width are whole ticks.
// - All outputs share one period.
// - Double-edge pulse may be either polarity.
// - In PWM mode, match updates land only at cycle start.
// - Without PWM mode, plain timer/counter.
// - Match zero ends and starts each cycle.
// - Single-edge output falls at own match.
// - Double-edge uses match n-1 and n.
// - Edge order sets pulse polarity.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] capIn,
  output logic [6:1] pwmPin,
  output logic irq
);
  logic [31:0] ctrl_r; // Control register
  logic [31:0] count_r; // Timer counter
  logic [31:0] prescale_r; // Prescale terminal value
  logic [31:0] pcount_r; // Prescale counter
  logic [20:0] matchCtrl_r; // Match actions
  logic [14:0] pwmSel_r; // Edge kinds and enables
  logic [6:0] release_r; // Pending shadow releases
  logic [6:0] intStat_r; // Sticky match events
  logic [6:0] intEn_r; // Interrupt enables
  logic [31:0] shadow_r [7]; // Software-written match values
  logic [31:0] active_r [7]; // Values the comparators use
  logic [1:0] capSync1_r; // First synchroniser stage
  logic [1:0] capSync2_r; // Second synchroniser stage
  logic [1:0] capPrev_r; // Previous synchronised level
  logic wrEn; // APB write strobe
  logic setup; // APB setup phase
  logic mapped; // Address decodes
  logic [31:0] rdMux; // Read data selection
  logic pwmMode;
  logic run;
  logic hold;
  logic capLvl, capLast, cntIn, tick;
  logic [6:0] hit, rstMask, stopMask, intMask;
  logic anyRst, anyStop, wrap;
  pwm_timer_pkg::count_src_t src;
  pwm_out_if outBus ();

  // Field extraction
  assign pwmMode = ctrl_r[pwm_timer_pkg::CTRL_PWM_BIT];
  assign run = ctrl_r[pwm_timer_pkg::CTRL_RUN_BIT];
  assign hold = ctrl_r[pwm_timer_pkg::CTRL_HOLD_BIT];
  assign src = pwm_timer_pkg::count_src_t'(ctrl_r[pwm_timer_pkg::CTRL_SRC_LSB +: 2]);

  // APB strobes; zero wait states
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Capture pin synchroniser, two flops before any logic
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      capSync1_r <= '0;
      capSync2_r <= '0;
      capPrev_r <= '0;
    end else begin
      capSync1_r <= capIn;
      capSync2_r <= capSync1_r;
      capPrev_r <= capSync2_r;
    end
  end

  assign capLvl = capSync2_r[ctrl_r[pwm_timer_pkg::CTRL_CAPSEL_BIT]];
  assign capLast = capPrev_r[ctrl_r[pwm_timer_pkg::CTRL_CAPSEL_BIT]];
  always_comb begin
    unique case (src)
      pwm_timer_pkg::SRC_CLOCK: cntIn = 1'b1;
      pwm_timer_pkg::SRC_RISE: cntIn = capLvl && !capLast;
      pwm_timer_pkg::SRC_FALL: cntIn = !capLvl && capLast;
      pwm_timer_pkg::SRC_BOTH: cntIn = capLvl != capLast;
    endcase
  end

  assign tick = run && !hold && cntIn && (pcount_r == prescale_r);

  // seven comparators, one-cycle hits on a counted tick
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      hit[i] = tick && (count_r == active_r[i]);
      intMask[i] = matchCtrl_r[i*pwm_timer_pkg::MC_WIDTH + pwm_timer_pkg::MC_INT];
      rstMask[i] = matchCtrl_r[i*pwm_timer_pkg::MC_WIDTH + pwm_timer_pkg::MC_RST];
      stopMask[i] = matchCtrl_r[i*pwm_timer_pkg::MC_WIDTH + pwm_timer_pkg::MC_STOP];
    end
    // match zero always ends the cycle in PWM mode
    rstMask[0] = rstMask[0] || pwmMode;
  end
  assign anyRst = |(hit & rstMask);
  assign anyStop = |(hit & stopMask);
  assign wrap = hit[0] && rstMask[0];

  // prescale counter restarts after terminal value
  always_ff @(posedge ref_clk) begin
    if (!rst_b || hold) begin
      pcount_r <= pwm_timer_pkg::RST_ZERO;
    end else if (run && cntIn) begin
      pcount_r <= (pcount_r == prescale_r) ? pwm_timer_pkg::RST_ZERO : pcount_r + 32'h1;
    end
  end

  // timer counter; clear beats stop, stop holds the match value
  always_ff @(posedge ref_clk) begin
    if (!rst_b || hold) begin
      count_r <= pwm_timer_pkg::RST_ZERO;
    end else if (tick) begin
      count_r <= anyRst ? pwm_timer_pkg::RST_ZERO : (anyStop ? count_r : count_r + 32'h1);
    end
  end

  // control register; stop-on-match drops the run bit
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl_r <= pwm_timer_pkg::RST_ZERO;
    end else if (wrEn && paddr == pwm_timer_pkg::OFF_CTRL) begin
      ctrl_r <= {25'h0, pwdata[6:4], 1'b0, pwdata[2:0]};
    end else if (anyStop) begin
      ctrl_r[pwm_timer_pkg::CTRL_RUN_BIT] <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prescale_r <= pwm_timer_pkg::RST_ZERO;
      matchCtrl_r <= '0;
      pwmSel_r <= '0;
      intEn_r <= '0;
    end else if (wrEn) begin
      if (paddr == pwm_timer_pkg::OFF_PRESCALE) prescale_r <= pwdata;
      if (paddr == pwm_timer_pkg::OFF_MATCH_CTRL) matchCtrl_r <= pwdata[20:0];
      if (paddr == pwm_timer_pkg::OFF_PWM_SEL) pwmSel_r <= {pwdata[14:9], 2'h0, pwdata[6:2], 2'h0};
      if (paddr == pwm_timer_pkg::OFF_INT_EN) intEn_r <= pwdata[6:0];
    end
  end

  // Shadow match values written by software
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 7; i++) shadow_r[i] <= pwm_timer_pkg::RST_ZERO;
    end else if (wrEn) begin
      for (int i = 0; i < 7; i++) begin
        if (paddr == pwm_timer_pkg::OFF_MATCH0 + 8'(4*i)) shadow_r[i] <= pwdata;
      end
    end
  end

  // release bits: software sets, wrap consumes; a new set wins
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      release_r <= '0;
    end else begin
      release_r <= (release_r & ~({7{pwmMode && wrap}}))
        | ((wrEn && paddr == pwm_timer_pkg::OFF_RELEASE) ? pwdata[6:0] : 7'h0);
    end
  end

  // active values load at the wrap; direct in timer mode
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 7; i++) active_r[i] <= pwm_timer_pkg::RST_ZERO;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (!pwmMode || (wrap && release_r[i])) active_r[i] <= shadow_r[i];
      end
    end
  end

  // sticky events; a new event beats a clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      intStat_r <= '0;
    end else begin
      intStat_r <= (intStat_r
        & ~((wrEn && paddr == pwm_timer_pkg::OFF_INT_CLR) ? pwdata[6:0] : 7'h0))
        | (hit & intMask);
    end
  end
  assign irq = |(intStat_r & intEn_r);

  // Read decode
  always_comb begin
    mapped = 1'b1;
    rdMux = pwm_timer_pkg::RST_ZERO;
    unique case (paddr)
      pwm_timer_pkg::OFF_CTRL: rdMux = ctrl_r;
      pwm_timer_pkg::OFF_COUNT: rdMux = count_r;
      pwm_timer_pkg::OFF_PRESCALE: rdMux = prescale_r;
      pwm_timer_pkg::OFF_PCOUNT: rdMux = pcount_r;
      pwm_timer_pkg::OFF_MATCH_CTRL: rdMux = {11'h0, matchCtrl_r};
      pwm_timer_pkg::OFF_PWM_SEL: rdMux = {17'h0, pwmSel_r};
      pwm_timer_pkg::OFF_RELEASE: rdMux = {25'h0, release_r};
      pwm_timer_pkg::OFF_INT_STAT: rdMux = {25'h0, intStat_r};
      pwm_timer_pkg::OFF_INT_CLR: rdMux = pwm_timer_pkg::RST_ZERO;
      pwm_timer_pkg::OFF_INT_EN: rdMux = {25'h0, intEn_r};
      default: begin
        mapped = 1'b0;
        for (int i = 0; i < 7; i++) begin
          if (paddr == pwm_timer_pkg::OFF_MATCH0 + 8'(4*i)) begin
            mapped = 1'b1;
            rdMux = shadow_r[i];
          end
        end
      end
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata <= pwm_timer_pkg::RST_ZERO;
    end else if (setup && !pwrite) begin
      prdata <= rdMux;
    end
  end

  // outputs built from one shared match set
  assign outBus.matchHit = hit;
  assign outBus.doubleSel = pwmSel_r[pwm_timer_pkg::SEL_DOUBLE_LSB + 1 +: 6];
  assign outBus.outEn = pwmSel_r[pwm_timer_pkg::SEL_OE_LSB + 1 +: 6];
  assign pwmPin = outBus.pwmOut;

  pwm_edge_gen edgeStage (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .bus(outBus)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_count_step: assert property (
    tick && !anyRst && !anyStop |=> count_r == $past(count_r) + 32'h1)
    else $error("counter did not step on tick");
  a_prescale_wrap: assert property (
    run && !hold && cntIn && pcount_r == prescale_r |=> pcount_r == 32'h0)
    else $error("prescale counter did not restart");
  a_cycle_wrap: assert property (
    pwmMode && hit[0] |=> count_r == 32'h0)
    else $error("match zero did not end the cycle");
  a_match_clear: assert property (
    anyRst |=> count_r == 32'h0 ##1 count_r == 32'h0 || $past(tick))
    else $error("clear-on-match failed");
  a_match_stop: assert property (
    anyStop && !(wrEn && paddr == pwm_timer_pkg::OFF_CTRL) |=> !run ##1 !tick)
    else $error("stop-on-match did not halt");
  a_event_flag: assert property (
    hit[1] && intMask[1] |=> intStat_r[1] ##0 (intEn_r[1] -> irq))
    else $error("match event not flagged");
  a_shadow_hold: assert property (
    pwmMode && !wrap |=> $stable(active_r[1]))
    else $error("active match changed mid-cycle");
  a_release_load: assert property (
    pwmMode && wrap && release_r[1] |=> active_r[1] == $past(shadow_r[1]) && !release_r[1])
    else $error("released value not loaded at wrap");
  a_timer_direct: assert property (
    !pwmMode && $stable(pwmMode) |=> active_r[2] == $past(shadow_r[2]))
    else $error("timer mode match not direct");
  c_release_wrap: cover property (pwmMode && wrap && release_r[1]);
  c_stop_match: cover property (anyStop ##1 !run);
  c_capture_count: cover property (src == pwm_timer_pkg::SRC_RISE && tick);
endmodule : pwm_timer
`default_nettype wire

// >>> verif/pwm_timer_tb.sv
/*
  Self-checking testbench for the match-based PWM timer: APB register
  access, timer and counter modes, match actions, interrupt and PWM.
  Assumes the register map and one-cycle output lag of the timer package.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module pwm_timer_tb;
  logic ref_clk; // 50 MHz clock
  logic rst_b; // Synchronous reset, active low
  logic psel, penable, pwrite, pready, pslverr, irq; // Bus and interrupt
  logic [7:0] paddr; // Byte address
  logic [31:0] pwdata, prdata, rd; // Write, read and captured data
  logic [1:0] capIn; // Capture pins
  logic [6:1] pwmPin; // PWM outputs
  logic err; // Captured slave error
  int miscompares, total_checks, hi, per; // Counters and pulse figures

  pwm_timer dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capIn(capIn), .pwmPin(pwmPin), .irq(irq));

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // One APB transfer: setup, then access until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write shorthand
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Pulse figures of one pin: high cycles and period, from one rise to the next
  task automatic measure(input int n);
    logic prev;
    int k;
    hi = 0;
    per = 0;
    k = 0;
    while (pwmPin[n] !== 1'b0 && k < 60) begin @(negedge ref_clk); k++; end
    while (pwmPin[n] !== 1'b1 && k < 60) begin @(negedge ref_clk); k++; end
    if (k < 60) begin
      hi = 1;
      per = 1;
      prev = 1'b1;
      forever begin
        @(negedge ref_clk);
        if (pwmPin[n] === 1'b1 && prev === 1'b0) break;
        prev = pwmPin[n];
        per++;
        if (prev === 1'b1) hi++;
      end
    end
  endtask : measure

  // Clear counters and actions before the stop, clear, count and single scenarios
  task automatic quiet();
    wr(pwm_timer_pkg::OFF_CTRL, 32'h0000_0002);
    wr(pwm_timer_pkg::OFF_MATCH_CTRL, 32'h0000_0000);
    wr(pwm_timer_pkg::OFF_PRESCALE, 32'h0000_0000);
    wr(pwm_timer_pkg::OFF_INT_CLR, 32'h0000_007f);
  endtask : quiet

  // Reset values, unmapped address, read-only and write-only places
  task automatic test_regs();
    apb(1'b0, pwm_timer_pkg::OFF_CTRL, 32'h0);
    `CHK(rd, pwm_timer_pkg::RST_ZERO)
    wr(pwm_timer_pkg::OFF_INT_STAT, 32'h0000_007f);
    apb(1'b0, pwm_timer_pkg::OFF_INT_STAT, 32'h0);
    `CHK(rd, pwm_timer_pkg::RST_ZERO)
    apb(1'b0, pwm_timer_pkg::OFF_INT_CLR, 32'h0);
    `CHK(rd, pwm_timer_pkg::RST_ZERO)
    apb(1'b0, 8'h30, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
    $display("test regs done");
  endtask : test_regs

  // Stop on match with prescaler, interrupt raise, mask and clear
  task automatic test_stop();
    int n;
    quiet();
    wr(pwm_timer_pkg::OFF_PRESCALE, 32'h0000_0002);
    wr(pwm_timer_pkg::OFF_MATCH0 + 8'h04, 32'h0000_0005);
    wr(pwm_timer_pkg::OFF_MATCH_CTRL, 32'h0000_0028);
    wr(pwm_timer_pkg::OFF_INT_EN, 32'h0000_0002);
    wr(pwm_timer_pkg::OFF_CTRL, 32'h0000_0001);
    n = 0;
    while (irq !== 1'b1 && n < 100) begin @(negedge ref_clk); n++; end
    // prescale spacing: six ticks of three inputs each
    `CHK(n >= 16 && n <= 21, 1'b1)
    apb(1'b0, pwm_timer_pkg::OFF_COUNT, 32'h0);
    `CHK(rd, 32'h0000_0005)
    apb(1'b0, pwm_timer_pkg::OFF_CTRL, 32'h0);
    `CHK(rd[pwm_timer_pkg::CTRL_RUN_BIT], 1'b0)
    apb(1'b0, pwm_timer_pkg::OFF_INT_STAT, 32'h0);
    `CHK(rd, 32'h0000_0002)
    wr(pwm_timer_pkg::OFF_INT_EN, 32'h0000_0000);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    wr(pwm_timer_pkg::OFF_INT_EN, 32'h0000_0002);
    @(negedge ref_clk);
    `CHK(irq, 1'b1)
    wr(pwm_timer_pkg::OFF_INT_CLR, 32'h0000_0002);
    @(negedge ref_clk);
    `CHK(irq, 1'b0)
    $display("test stop done");
  endtask : test_stop

  // Clear and event on match 2, event only on match 3, counter keeps running
  task automatic test_clear();
    int i;
    quiet();
    wr(pwm_timer_pkg::OFF_MATCH0 + 8'h08, 32'h0000_0003);
    wr(pwm_timer_pkg::OFF_MATCH0 + 8'h0c, 32'h0000_0001);
    wr(pwm_timer_pkg::OFF_MATCH_CTRL, 32'h0000_02c0);
    wr(pwm_timer_pkg::OFF_CTRL, 32'h0000_0001);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, pwm_timer_pkg::OFF_COUNT, 32'h0);
      `CHK(rd <= 32'h0000_0003, 1'b1)
    end
    apb(1'b0, pwm_timer_pkg::OFF_INT_STAT, 32'h0);
    `CHK(rd, 32'h0000_000c)
    $display("test clear done");
  endtask : test_clear

  // Counter mode: rising edges of pin 0, both edges of pin 1, falling edges of pin 0
  task automatic test_count();
    int m, i;
    for (m = 0; m < 3; m++) begin
      quiet();
      wr(pwm_timer_pkg::OFF_CTRL,
        (m == 0) ? 32'h0000_0011 : ((m == 1) ? 32'h0000_0071 : 32'h0000_0021));
      for (i = 0; i < 6; i++) begin
        repeat (4) @(posedge ref_clk);
        capIn <= capIn ^ ((m == 1) ? 2'h2 : 2'h1);
      end
      repeat (8) @(posedge ref_clk);
      apb(1'b0, pwm_timer_pkg::OFF_COUNT, 32'h0);
      `CHK(rd, (m == 1) ? 32'h0000_0006 : 32'h0000_0003)
    end
    $display("test count done");
  endtask : test_count

  // Single-edge outputs, shared period, shadow release
  task automatic test_single();
    quiet();
    wr(pwm_timer_pkg::OFF_MATCH0, 32'h0000_0009);
    wr(pwm_timer_pkg::OFF_MATCH0 + 8'h04, 32'h0000_0003);
    wr(pwm_timer_pkg::OFF_MATCH0 + 8'h08, 32'h0000_0006);
    wr(pwm_timer_pkg::OFF_PWM_SEL, 32'h0000_0600);
    wr(pwm_timer_pkg::OFF_CTRL, 32'h0000_0005);
    measure(1);
    `CHK(hi, 4)
    `CHK(per, 10)
    measure(2);
    `CHK(hi, 7)
    `CHK(per, 10)
    wr(pwm_timer_pkg::OFF_MATCH0 + 8'h04, 32'h0000_0006);
    measure(1);
    `CHK(hi, 4)
    wr(pwm_timer_pkg::OFF_RELEASE, 32'h0000_0002);
    measure(1);
    measure(1);
    `CHK(hi, 7)
    wr(pwm_timer_pkg::OFF_MATCH0 + 8'h08, 32'h0000_0009);
    wr(pwm_timer_pkg::OFF_RELEASE, 32'h0000_0004);
    repeat (12) @(posedge ref_clk);
    measure(2);
    `CHK(per, 0)
    $display("test single done");
  endtask : test_single

  // Double-edge output 2: positive, then negative pulse
  task automatic test_double();
    int m;
    for (m = 0; m < 2; m++) begin
      wr(pwm_timer_pkg::OFF_PWM_SEL, 32'h0000_0404);
      wr(pwm_timer_pkg::OFF_MATCH0 + 8'h04, (m == 0) ? 32'h0000_0002 : 32'h0000_0006);
      wr(pwm_timer_pkg::OFF_MATCH0 + 8'h08, (m == 0) ? 32'h0000_0006 : 32'h0000_0002);
      wr(pwm_timer_pkg::OFF_RELEASE, 32'h0000_0006);
      measure(2);
      measure(2);
      `CHK(hi, (m == 0) ? 4 : 6)
      `CHK(per, 10)
      `CHK(pwmPin[1], 1'b0)
    end
    $display("test double done");
  endtask : test_double

  // Counts, verdict and end of run
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Watchdog against a hang
  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, capIn} = '0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    test_regs();
    test_stop();
    test_clear();
    test_count();
    test_single();
    test_double();
    finish_test();
  end
endmodule : pwm_timer_tb
`default_nettype wire
